// ---- sie_filter.sv ----
// On/off delay filter for one safety input terminal.
// Assumes a synchronised input and a one-cycle millisecond tick.
`timescale 1ns/100ps
module sie_filter
    import sie_pkg::*;
(
    // Clock and reset
    input  wire logic                  clk_sys,
    input  wire logic                  rstn,
    // Timing and settings
    input  wire logic                  tick_ms,
    input  wire logic [`SIE_DLY_W-1:0] rise_t,
    input  wire logic [`SIE_DLY_W-1:0] fall_t,
    // Input and filtered level
    input  wire logic                  din,
    output logic                       q
);
    sie_flt_type           cur;
    sie_flt_type           nxt;
    logic [`SIE_DLY_W-1:0] dly;

    // Level must outlast the delay before it is taken
    always_comb
    begin
        nxt = cur;
        dly = din ? rise_t : fall_t;
        if (din == cur.q)
            nxt.cnt = '0;
        else if (dly == '0)
            nxt.q = din;
        else if (tick_ms)
        begin
            if (cur.cnt == dly)
            begin
                nxt.q   = din;
                nxt.cnt = '0;
            end
            else
                nxt.cnt = cur.cnt + 1'b1;
        end
    end

    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
            cur <= '0;
        else
            cur <= nxt;
    end

    assign q = cur.q;

    property p_no_early_rise;
        @(posedge clk_sys) disable iff (!rstn)
        (rise_t != '0 && din && !cur.q && !tick_ms) |=> !cur.q;
    endproperty
    a_no_early_rise: assert property (p_no_early_rise) else $error("filter rose early");

    property p_zero_fall;
        @(posedge clk_sys) disable iff (!rstn)
        (fall_t == '0 && !din && cur.q) |=> !cur.q;
    endproperty
    a_zero_fall: assert property (p_zero_fall) else $error("zero fall delay not immediate");
endmodule

// ---- sie_pair.sv ----
// Complementary dual-channel evaluation of one terminal pair.
// Assumes filtered channel levels and a one-cycle 10 ms tick.
`timescale 1ns/100ps
module sie_pair
    import sie_pkg::*;
(
    // Clock and reset
    input  wire logic                    clk_sys,
    input  wire logic                    rstn,
    // Timing and settings
    input  wire logic                    tick_10,
    input  wire logic                    en,
    input  wire logic [`SIE_DISC_W-1:0]  disc_t,
    input  wire logic [`SIE_LATCH_W-1:0] latch_t,
    // Channels
    input  wire logic                    f_even,
    input  wire logic                    f_odd,
    input  wire logic                    tp_even,
    input  wire logic                    tp_odd,
    // Views
    output logic                         pv,
    output logic                         st_even,
    output logic                         st_odd,
    output logic                         red_even,
    output logic                         red_odd,
    output logic                         fl_even,
    output logic                         fl_odd,
    output logic                         yel_even,
    output logic                         yel_odd,
    output logic                         err_ev
);
    sie_pair_type cur;
    sie_pair_type nxt;
    logic         tpe;
    logic         tpo;
    logic         incons;
    logic         dto;
    logic         cause;
    logic         ke;
    logic         ko;
    logic         km;

    // pulse faults and shorts via mismatch
    assign tpe    = en & tp_even;
    assign tpo    = en & tp_odd;
    assign incons = en & (f_even == f_odd);
    // inconsistency outlasting the window
    // Compare with >= so a window shortened mid-count still times out
    assign dto    = incons && (cur.dcnt >= disc_t);
    assign cause  = tpe | tpo | dto;

    always_comb
    begin
        nxt    = cur;
        nxt.ev = 1'b0;
        // discrepancy timer in 10 ms steps
        if (!incons)
            nxt.dcnt = '0;
        else if (tick_10 && !dto)
            nxt.dcnt = cur.dcnt + 1'b1;
        if (cause)
        begin
            nxt.hold  = 1'b1;
            nxt.hcnt  = '0;
            nxt.h_tpe = cur.h_tpe | tpe;
            nxt.h_tpo = cur.h_tpo | tpo;
            nxt.h_dis = cur.h_dis | dto;
            nxt.ev    = !cur.hold;
        end
        else if (cur.hold)
        begin
            if (latch_t == '0 || (tick_10 && cur.hcnt >= latch_t))
            begin
                nxt.hold  = 1'b0;
                nxt.h_tpe = 1'b0;
                nxt.h_tpo = 1'b0;
                nxt.h_dis = 1'b0;
            end
            else if (tick_10)
                nxt.hcnt = cur.hcnt + 1'b1;
        end
        // all views follow the held kinds while the pair is enabled
        ke = tpe | (nxt.hold & nxt.h_tpe);
        ko = tpo | (nxt.hold & nxt.h_tpo);
        km = incons | (nxt.hold & nxt.h_dis);
        {nxt.pv, nxt.st_e, nxt.st_o} = 3'b011;
        {nxt.red_e, nxt.red_o, nxt.fl_e, nxt.fl_o} = 4'h0;
        {nxt.yel_e, nxt.yel_o} = 2'b00;
        if (!en)
            nxt.pv = 1'b0;
        else if (ke | ko)
        begin
            {nxt.st_e, nxt.st_o} = 2'b00;
            {nxt.red_e, nxt.red_o} = 2'b11;
            nxt.fl_e = ko & ~ke;
            nxt.fl_o = ke & ~ko;
        end
        else if (km)
        begin
            {nxt.st_e, nxt.st_o} = 2'b00;
            {nxt.red_e, nxt.red_o} = 2'b11;
        end
        // true only for even on, odd off
        else
        begin
            nxt.pv    = f_even;
            nxt.yel_e = f_even;
            nxt.yel_o = f_odd;
        end
    end

    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
            cur <= '0;
        else
            cur <= nxt;
    end

    assign pv       = cur.pv;
    assign st_even  = cur.st_e;
    assign st_odd   = cur.st_o;
    assign red_even = cur.red_e;
    assign red_odd  = cur.red_o;
    assign fl_even  = cur.fl_e;
    assign fl_odd   = cur.fl_o;
    assign yel_even = cur.yel_e;
    assign yel_odd  = cur.yel_o;
    assign err_ev   = cur.ev;

    property p_mismatch;
        @(posedge clk_sys) disable iff (!rstn)
        (en && f_even == f_odd) |=> (!pv && !st_even && !st_odd && red_even && red_odd);
    endproperty
    a_mismatch: assert property (p_mismatch) else $error("mismatch not flagged");

    property p_tp_even;
        @(posedge clk_sys) disable iff (!rstn)
        (en && tp_even && !tp_odd && !cur.h_tpo) |=> (!pv && !st_even && red_even && !fl_even && fl_odd);
    endproperty
    a_tp_even: assert property (p_tp_even) else $error("even pulse fault view wrong");

    // true value needs a clean pair
    property p_pv_true;
        @(posedge clk_sys) disable iff (!rstn)
        pv |-> $past(en) && $past(f_even) && !$past(f_odd) && !$past(tp_even) && !$past(tp_odd);
    endproperty
    a_pv_true: assert property (p_pv_true) else $error("value true without clean pair");

    sequence s_tp_gone;
        (en && tp_even && latch_t != '0) ##1 (en && !tp_even && latch_t != '0);
    endsequence
    property p_latch;
        @(posedge clk_sys) disable iff (!rstn)
        s_tp_gone |=> (!pv && !st_even && red_even);
    endproperty
    a_latch: assert property (p_latch) else $error("error dropped before latch time");
endmodule

// ---- sie_params.svh ----
// Constants of the safety input evaluator: offsets, fields, resets, timing.
// Assumes inclusion by bare name from the package, whose macros the modules then use.
`ifndef SIE_PARAMS_SVH
`define SIE_PARAMS_SVH
// ==================== Timing
`define SIE_CLK_PERIOD_NS 50
`define SIE_TICK_MS_NS    1000000
`define SIE_STEP_MS       10
`define SIE_BLINK_MS      250
// ==================== Field widths, limits and reset values
`define SIE_DLY_W         10
`define SIE_DLY_MAX       10'd1000
`define SIE_DLY_RST       10'd0
`define SIE_DLY_LC_FALL   10'd1
`define SIE_LATCH_W       13
`define SIE_LATCH_MAX     13'd6553
`define SIE_LATCH_RST     13'd100
`define SIE_DISC_W        12
`define SIE_DISC_MIN      12'd1
`define SIE_DISC_MAX      12'd3000
`define SIE_DISC_RST      12'd1
// ==================== Register offsets
`define SIE_REG_MODE      8'h00
`define SIE_REG_LATCH     8'h04
`define SIE_REG_DISC      8'h08
`define SIE_REG_DEVLC     8'h0c
`define SIE_REG_IRQST     8'h10
`define SIE_REG_IRQMSK    8'h14
`define SIE_REG_STATE     8'h18
`define SIE_REG_FLT_PAGE  2'b01
// ==================== Field positions
`define SIE_FLT_RISE_LSB  0
`define SIE_FLT_FALL_LSB  16
`define SIE_ST_PV_LSB     0
`define SIE_ST_STAT_LSB   8
`endif

// ---- sie_pkg.sv ----
// Types shared by the safety input evaluator modules.
// Assumes sie_params.svh sits in the same folder.
package sie_pkg;
`include "sie_params.svh"

    // ====================
    // Delay filter state
    typedef struct packed {
        logic                  q;
        logic [`SIE_DLY_W-1:0] cnt;
    } sie_flt_type;

    // ====================
    // Complementary pair state
    typedef struct packed {
        logic [`SIE_DISC_W-1:0]  dcnt;
        logic [`SIE_LATCH_W-1:0] hcnt;
        logic                    hold;
        logic                    h_tpe;
        logic                    h_tpo;
        logic                    h_dis;
        logic                    ev;
        logic                    pv;
        logic                    st_e;
        logic                    st_o;
        logic                    red_e;
        logic                    red_o;
        logic                    fl_e;
        logic                    fl_o;
        logic                    yel_e;
        logic                    yel_o;
    } sie_pair_type;
endpackage

// ---- sie_sensor_model.sv ----
// Model of the safety switches wired to the terminals.
// Assumes the bench sets the wanted contact levels.
`timescale 1ns/100ps
module sie_sensor_model
(
    // Clock
    input  wire logic       clk_sys,
    // Wanted contact levels
    input  wire logic [3:0] lvl,
    // Terminal pins
    output logic      [3:0] term_in
);
    // ====================
    // Contacts switch just after an edge, never between edges
    always_ff @(posedge clk_sys)
    begin
        term_in <= lvl;
    end
endmodule

// ---- sie_top.sv ----
// Safety input evaluator: terminal filters, complementary pair evaluation,
// error latching, indicator drive, register port and interrupt.
// Assumes a 20 MHz clk_sys, asynchronous terminal pins and same-clock
// pulse fault flags from the test pulse diagnosis.
//
// Strobed register access and the placing of the registers are this design's own decisions.
`timescale 1ns/100ps
module sie_top
    import sie_pkg::*;
#(
    parameter int NPAIR     = 2,
    parameter int MS_CYCLES = `SIE_TICK_MS_NS / `SIE_CLK_PERIOD_NS
)
(
    // Clock and reset
    input  wire logic               clk_sys,
    input  wire logic               rstn,
    // Register port
    input  wire logic [7:0]         addr,
    input  wire logic [31:0]        wdata,
    input  wire logic               wr,
    input  wire logic               rd,
    output logic      [31:0]        rdata,
    // Terminals
    input  wire logic [2*NPAIR-1:0] term_in,
    input  wire logic [2*NPAIR-1:0] tp_fault,
    // Process data and status
    output logic      [NPAIR-1:0]   pair_pv,
    output logic      [2*NPAIR-1:0] term_status,
    // Indicators
    output logic      [2*NPAIR-1:0] led_red,
    output logic      [2*NPAIR-1:0] led_yellow,
    // Interrupt
    output logic                    irq
);
    localparam int NT = 2 * NPAIR;

    // ====================
    // Elaboration checks
    generate
        if (NPAIR < 1 || NPAIR > 8 || MS_CYCLES < 2 || MS_CYCLES > 32767)
        begin : g_bad_cfg
            $error("sie_top: unsupported NPAIR or MS_CYCLES");
        end
    endgenerate

    // ====================
    // State of the block
    typedef struct packed {
        logic [NT-1:0]                    s1;
        logic [NT-1:0]                    s2;
        logic [14:0]                      ms_cnt;
        logic                             tick_ms;
        logic [3:0]                       cnt10;
        logic                             tick_10;
        logic [7:0]                       bl_cnt;
        logic                             blink;
        logic [NPAIR-1:0]                 mode;
        logic [`SIE_LATCH_W-1:0]          latch_t;
        logic [`SIE_DISC_W-1:0]           disc_t;
        logic [NT-1:0]                    dev_lc;
        logic [NT-1:0][`SIE_DLY_W-1:0]    rise;
        logic [NT-1:0][`SIE_DLY_W-1:0]    fall;
        logic [NPAIR-1:0]                 irq_st;
        logic [NPAIR-1:0]                 irq_mask;
        logic [31:0]                      rdata;
        logic                             irq;
        logic [NPAIR-1:0]                 pv;
        logic [NT-1:0]                    st;
        logic [NT-1:0]                    red;
        logic [NT-1:0]                    yel;
    } sie_top_type;

    sie_top_type      cur;
    sie_top_type      nxt;
    logic [NT-1:0]    filt;
    logic [NPAIR-1:0] p_pv;
    logic [NT-1:0]    p_st;
    logic [NT-1:0]    p_red;
    logic [NT-1:0]    p_fl;
    logic [NT-1:0]    p_yel;
    logic [NPAIR-1:0] p_ev;
    logic [3:0]       fidx;
    logic             fhit;
    logic [31:0]      rd_val;

    assign fidx = addr[5:2];
    assign fhit = (addr[7:6] == `SIE_REG_FLT_PAGE) && ({1'b0, fidx} < 5'(NT));

    // ====================
    // Terminal filters
    // filters sit ahead of the pairs
    genvar gi;
    generate
        for (gi = 0; gi < NT; gi++)
        begin : g_flt
            sie_filter u_flt (
                .clk_sys (clk_sys),
                .rstn    (rstn),
                .tick_ms (cur.tick_ms),
                .rise_t  (cur.rise[gi]),
                .fall_t  (cur.fall[gi]),
                .din     (cur.s2[gi]),
                .q       (filt[gi])
            );
        end
    endgenerate

    // ====================
    // Pair evaluators
    generate
        for (gi = 0; gi < NPAIR; gi++)
        begin : g_pair
            sie_pair u_pair (
                .clk_sys  (clk_sys),
                .rstn     (rstn),
                .tick_10  (cur.tick_10),
                .en       (cur.mode[gi]),
                .disc_t   (cur.disc_t),
                .latch_t  (cur.latch_t),
                .f_even   (filt[2*gi]),
                .f_odd    (filt[2*gi+1]),
                .tp_even  (tp_fault[2*gi]),
                .tp_odd   (tp_fault[2*gi+1]),
                .pv       (p_pv[gi]),
                .st_even  (p_st[2*gi]),
                .st_odd   (p_st[2*gi+1]),
                .red_even (p_red[2*gi]),
                .red_odd  (p_red[2*gi+1]),
                .fl_even  (p_fl[2*gi]),
                .fl_odd   (p_fl[2*gi+1]),
                .yel_even (p_yel[2*gi]),
                .yel_odd  (p_yel[2*gi+1]),
                .err_ev   (p_ev[gi])
            );
        end
    endgenerate

    // ====================
    // Read multiplexer, unmapped offsets read zero
    always_comb
    begin
        rd_val = 32'h0;
        case (addr)
            `SIE_REG_MODE:   rd_val[NPAIR-1:0] = cur.mode;
            `SIE_REG_LATCH:  rd_val[`SIE_LATCH_W-1:0] = cur.latch_t;
            `SIE_REG_DISC:   rd_val[`SIE_DISC_W-1:0] = cur.disc_t;
            `SIE_REG_DEVLC:  rd_val[NT-1:0] = cur.dev_lc;
            `SIE_REG_IRQST:  rd_val[NPAIR-1:0] = cur.irq_st;
            `SIE_REG_IRQMSK: rd_val[NPAIR-1:0] = cur.irq_mask;
            `SIE_REG_STATE:
            begin
                rd_val[`SIE_ST_PV_LSB +: NPAIR] = cur.pv;
                rd_val[`SIE_ST_STAT_LSB +: NT]  = cur.st;
            end
            default:
            begin
                if (fhit)
                begin
                    rd_val[`SIE_FLT_RISE_LSB +: `SIE_DLY_W] = cur.rise[fidx];
                    rd_val[`SIE_FLT_FALL_LSB +: `SIE_DLY_W] = cur.fall[fidx];
                end
            end
        endcase
    end

    // ====================
    // Next state
    always_comb
    begin
        nxt = cur;
        // Two-stage synchroniser for the pins
        nxt.s1 = term_in;
        nxt.s2 = cur.s1;
        // shared millisecond and 10 ms ticks
        nxt.tick_ms = 1'b0;
        nxt.tick_10 = 1'b0;
        if (cur.ms_cnt == 15'(MS_CYCLES - 1))
        begin
            nxt.ms_cnt  = '0;
            nxt.tick_ms = 1'b1;
        end
        else
            nxt.ms_cnt = cur.ms_cnt + 1'b1;
        if (cur.tick_ms)
        begin
            if (cur.cnt10 == 4'(`SIE_STEP_MS - 1))
            begin
                nxt.cnt10   = '0;
                nxt.tick_10 = 1'b1;
            end
            else
                nxt.cnt10 = cur.cnt10 + 1'b1;
            // Flash phase for partner indicators
            if (cur.bl_cnt == 8'(`SIE_BLINK_MS - 1))
            begin
                nxt.bl_cnt = '0;
                nxt.blink  = ~cur.blink;
            end
            else
                nxt.bl_cnt = cur.bl_cnt + 1'b1;
        end
        // Register writes; out-of-range values are ignored
        if (wr)
        begin
            case (addr)
                `SIE_REG_MODE:   nxt.mode = wdata[NPAIR-1:0];
                `SIE_REG_LATCH:
                    if (wdata[31:`SIE_LATCH_W] == '0 && wdata[`SIE_LATCH_W-1:0] <= `SIE_LATCH_MAX)
                        nxt.latch_t = wdata[`SIE_LATCH_W-1:0];
                `SIE_REG_DISC:
                    if (wdata[31:`SIE_DISC_W] == '0 && wdata[`SIE_DISC_W-1:0] >= `SIE_DISC_MIN
                        && wdata[`SIE_DISC_W-1:0] <= `SIE_DISC_MAX)
                        nxt.disc_t = wdata[`SIE_DISC_W-1:0];
                `SIE_REG_DEVLC:
                begin
                    nxt.dev_lc = wdata[NT-1:0];
                    // device type reloads the fall default
                    for (int t = 0; t < NT; t++)
                        nxt.fall[t] = wdata[t] ? `SIE_DLY_LC_FALL : `SIE_DLY_RST;
                end
                `SIE_REG_IRQMSK: nxt.irq_mask = wdata[NPAIR-1:0];
                default:
                begin
                    if (fhit && wdata[`SIE_FLT_RISE_LSB +: `SIE_DLY_W] <= `SIE_DLY_MAX
                        && wdata[`SIE_FLT_FALL_LSB +: `SIE_DLY_W] <= `SIE_DLY_MAX)
                    begin
                        nxt.rise[fidx] = wdata[`SIE_FLT_RISE_LSB +: `SIE_DLY_W];
                        nxt.fall[fidx] = wdata[`SIE_FLT_FALL_LSB +: `SIE_DLY_W];
                    end
                end
            endcase
        end
        // Read data stands one cycle only
        nxt.rdata = rd ? rd_val : 32'h0;
        // Sticky events; a new event wins over the read clear
        if (rd && addr == `SIE_REG_IRQST)
            nxt.irq_st = p_ev;
        else
            nxt.irq_st = cur.irq_st | p_ev;
        nxt.irq = |(nxt.irq_st & nxt.irq_mask);
        // indicators and flags from the pair views
        nxt.pv  = p_pv;
        nxt.st  = p_st;
        nxt.red = p_red & (~p_fl | {NT{cur.blink}});
        nxt.yel = p_yel;
    end

    // ====================
    // State register; reset restores defaults
    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            cur         <= '0;
            cur.latch_t <= `SIE_LATCH_RST;
            cur.disc_t  <= `SIE_DISC_RST;
        end
        else
            cur <= nxt;
    end

    assign rdata       = cur.rdata;
    assign irq         = cur.irq;
    assign pair_pv     = cur.pv;
    assign term_status = cur.st;
    assign led_red     = cur.red;
    assign led_yellow  = cur.yel;

    // ====================
    // Checks

    property p_tick_lone;
        @(posedge clk_sys) disable iff (!rstn)
        cur.tick_ms |=> !cur.tick_ms;
    endproperty
    a_tick_lone: assert property (p_tick_lone) else $error("ms tick longer than one cycle");

    // Interrupt rises only on a fresh event or a write to the interrupt mask
    property p_irq_cause;
        @(posedge clk_sys) disable iff (!rstn)
        $rose(irq) |-> ($past(p_ev) != '0 || ($past(wr) && $past(addr) == `SIE_REG_IRQMSK));
    endproperty
    a_irq_cause: assert property (p_irq_cause) else $error("interrupt rose without cause");

    property p_latch_range;
        @(posedge clk_sys) disable iff (!rstn)
        1'b1 |-> cur.latch_t <= `SIE_LATCH_MAX;
    endproperty
    a_latch_range: assert property (p_latch_range) else $error("latch time out of range");
endmodule

// ---- sie_top_test.sv ----
// Self-checking bench of the safety input evaluator.
// Assumes two pairs and a shortened millisecond tick of 4 cycles.
`timescale 1ns/100ps
module sie_top_test;
    logic        clk_sys, rstn, wr, rd;
    logic [7:0]  addr;
    logic [31:0] wdata, rdata;
    logic [3:0]  lvl, term_in, tp_fault, term_status, led_red, led_yellow;
    logic [1:0]  pair_pv;
    logic        irq, r1;
    int          fails, cmp_count, bad, tog;
    // ====================
    // Design and switches
    sie_top #(.NPAIR(2), .MS_CYCLES(4)) i_sie_top (.clk_sys(clk_sys), .rstn(rstn), .addr(addr),
        .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .term_in(term_in), .tp_fault(tp_fault),
        .pair_pv(pair_pv), .term_status(term_status), .led_red(led_red), .led_yellow(led_yellow), .irq(irq));
    sie_sensor_model i_sie_sensor_model (.clk_sys(clk_sys), .lvl(lvl), .term_in(term_in));
    // ====================
    // Helpers
    task chk(input string n, input logic [31:0] s, input logic [31:0] e);
        cmp_count++;
        if (s !== e)
        begin
            fails++;
            $display("unexpected %s expected %h seen %h", n, e, s);
        end
    endtask
    task wreg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        wr <= 1'b1; addr <= a; wdata <= d;
        @(posedge clk_sys);
        wr <= 1'b0;
    endtask
    task rreg(input logic [7:0] a, input logic [31:0] e);
        @(posedge clk_sys);
        rd <= 1'b1; addr <= a;
        @(posedge clk_sys);
        rd <= 1'b0;
        #1 chk("rdata", rdata, e);
    endtask
    task wt(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask
    // Short glitch then back to a clean pair, counting dropped values
    task glitch(input logic [3:0] v);
        bad = 0;
        lvl <= v;
        for (int k = 0; k < 48; k++)
        begin
            @(posedge clk_sys) #1;
            if (k == 7) lvl <= 4'h5;
            if (pair_pv[0] !== 1'b1) bad++;
        end
    endtask
    task stop_test;
        $display("compares %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    // ====================
    // Clock and hang guard
    initial
    begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end
    initial
    begin
        wt(20000);
        fails++;
        stop_test;
    end
    // ====================
    // Main sequence
    initial
    begin
        rstn = 1'b0; wr = 1'b0; rd = 1'b0; addr = 8'h00; wdata = 32'h0; lvl = 4'h0; tp_fault = 4'h0;
        fails = 0; cmp_count = 0;
        wt(20);
        rstn <= 1'b1;
        rreg(8'h04, 32'h64);
        rreg(8'h08, 32'h1);
        rreg(8'h00, 32'h0);
        rreg(8'h20, 32'h0);
        wreg(8'h04, 32'h199a);
        rreg(8'h04, 32'h64);
        // Shortest latch that still spans a glitch, on our side
        wreg(8'h04, 32'h2);
        wreg(8'h0c, 32'h1);
        rreg(8'h40, 32'h10000);
        wreg(8'h0c, 32'h0);
        // Clean levels settle before the pairs are enabled, so no false discrepancy
        lvl <= 4'h5; wt(8);
        wreg(8'h14, 32'h1);
        wreg(8'h00, 32'h3);
        wt(12);
        chk("pv", {pair_pv, term_status, led_yellow, led_red}, 32'h3f50);
        rreg(8'h18, 32'hf03);
        lvl <= 4'h6; wt(12);
        chk("pv", {pair_pv, term_status, led_yellow, led_red}, 32'h2f60);
        lvl <= 4'h7; wt(12);
        chk("pv", {pair_pv, term_status, led_red}, 32'h2c3);
        wt(50);
        lvl <= 4'h5; wt(40);
        chk("hold", {pair_pv[0], term_status[1:0]}, 32'h0);
        wt(200);
        chk("pv", pair_pv, 2'b11);
        chk("irq", irq, 1'b1);
        rreg(8'h10, 32'h1);
        wt(2);
        chk("irq", irq, 1'b0);
        // Pulse fault on terminal 0, partner flashes
        tp_fault <= 4'h1; wt(5); bad = 0; tog = 0; r1 = led_red[1];
        repeat (1100)
        begin
            @(posedge clk_sys) #1;
            if ({led_red[0], pair_pv[0], term_status[1:0]} !== 4'h8) bad++;
            if (led_red[1] !== r1) tog++;
            r1 = led_red[1];
        end
        chk("fault", bad, 0);
        chk("flash", tog > 0, 1'b1);
        tp_fault <= 4'h0; wt(300);
        // Delay filters ahead of the pair
        wreg(8'h44, 32'h3);
        wreg(8'h40, 32'h30000);
        wreg(8'h40, 32'h3e9);
        rreg(8'h40, 32'h30000);
        wt(40);
        glitch(4'h7);
        chk("rise", bad, 0);
        glitch(4'h4);
        chk("fall", bad, 0);
        stop_test;
    end
endmodule
